/* File: rhc_pkg.sv */
package rhc_pkg;

	// ==========================================================
	// Storage sizes
	localparam int FLAG_COUNT  = 8192;
	localparam int FLAG_WORDS  = 256;
	localparam int REG_COUNT   = 4096;
	localparam int TC_COUNT    = 1600;
	localparam int TC_WIDTH    = 31;
	localparam int CPU_COUNT   = 7;

	// ==========================================================
	// Declaration limits and reset values
	localparam logic [13:0] FLAG_DECL_RST = 14'h0000;
	localparam logic [13:0] FLAG_DECL_MAX = 14'h2000;
	localparam logic [8:0]  TIMER_MAX     = 9'h1C2;
	localparam logic [8:0]  TC_DECL_RST   = 9'h000;
	localparam logic [9:0]  TIMEBASE_RST  = 10'h001;
	localparam logic [9:0]  TIMEBASE_MIN  = 10'h001;
	localparam logic [9:0]  TIMEBASE_MAX  = 10'h3E8;

	// ==========================================================
	// Exception block numbers
	localparam logic [4:0] COLD_START_INIT_BLOCK = 5'h10;
	localparam logic [4:0] BATTERY_FAIL_BLOCK    = 5'h02;

	// ==========================================================
	// Byte offsets on the register bus
	localparam logic [14:0] OFS_FLAG_DECL = 15'h0000;
	localparam logic [14:0] OFS_TC_DECL   = 15'h0004;
	localparam logic [14:0] OFS_TIMEBASE  = 15'h0008;
	localparam logic [14:0] OFS_STATUS    = 15'h000C;
	localparam logic [14:0] OFS_CAL_DATE  = 15'h0010;
	localparam logic [14:0] OFS_CAL_TIME  = 15'h0014;
	localparam logic [14:0] BASE_FLAGS    = 15'h1000;
	localparam logic [14:0] END_FLAGS     = 15'h1400;
	localparam logic [14:0] BASE_TC       = 15'h2000;
	localparam logic [14:0] END_TC        = 15'h3900;
	localparam logic [14:0] BASE_REGS     = 15'h4000;

	// ==========================================================
	// Field positions
	localparam int ST_HALT_LSB  = 0;
	localparam int ST_SW_HALT   = 7;
	localparam int ST_CLEARING  = 8;
	localparam int ST_BATT_OK   = 9;
	localparam int ST_OUT_RESET = 10;
	localparam int CD_DATE_LSB  = 0;
	localparam int CD_MONTH_LSB = 5;
	localparam int CD_YEAR_LSB  = 9;
	localparam int CD_WDAY_LSB  = 16;
	localparam int CD_WEEK_LSB  = 19;
	localparam int CT_SEC_LSB   = 0;
	localparam int CT_MIN_LSB   = 8;
	localparam int CT_HOUR_LSB  = 16;

	// ==========================================================
	// Timing
	localparam int CLK_HZ       = 25000000;
	localparam int DEBOUNCE_MS  = 10;
	localparam int TB_UNIT_MS   = 10;
	localparam int CLEAR_MS     = 1000;
	localparam int SECOND_MS    = 1000;
	localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int TB_UNIT_CYC  = CLK_HZ / 1000 * TB_UNIT_MS;
	localparam int CLEAR_CYC    = CLK_HZ / 1000 * CLEAR_MS;
	localparam int SECOND_CYC   = CLK_HZ / 1000 * SECOND_MS;

	typedef enum {SEQ_IDLE, SEQ_WALK, SEQ_SETTLE} rhc_seq_type;
	typedef enum {RG_CTRL, RG_FLAG, RG_TC, RG_REG, RG_NONE} rhc_region_type;

endpackage : rhc_pkg

/* File: rhc_run_halt_clear.sv */
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// How it works
// R1: 8192 flags, split by non-volatile count.
// R2: 4096 32-bit registers never cleared.
// R3: 1600 31-bit elements, at most 450 timers.
// R4: Counters kept, timers cleared on cold start.
// R5: Element values stored non-negative, no floats.
// R6: Timers decrement on shared 10ms..10s base.
// R7: Calendar with week, weekday, date and time.
// R8: Registers hold signed two's complement words.
// R9: Switch in halt halts every processor.
// R10: Switch halt blocks tool run commands.
// R11: Halt to run triggers cold start, block 16, only while the sequencer is idle.
// R12: Clear key at that edge clears all flags and elements.
// R13: Clear key otherwise has no effect.
// R14: Yellow lamp lit during clear, about 1s.
// R15: Clear key needs the enable jumper.
// R16: Disable jumper ignores switch entirely.
// R17: Output reset on: processor 0 halts all.
// R18: Output reset off: outputs kept, others halt.
// R19: Halt of processors 1-6 stays local.
// R20: Red lamp lit while halt in effect.
// R21: Battery fault: red lamp, block 2 raised.
// R22: Switch and key synchronised and debounced.
module rhc_run_halt_clear #(
	parameter int DEBOUNCE_CYC = rhc_pkg::DEBOUNCE_CYC,
	parameter int TB_UNIT_CYC  = rhc_pkg::TB_UNIT_CYC,
	parameter int CLEAR_CYC    = rhc_pkg::CLEAR_CYC,
	parameter int SECOND_CYC   = rhc_pkg::SECOND_CYC
) (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic [31:0]      o_hrdata,
	output logic             o_hresp,
	input  wire logic        i_halt_switch,
	input  wire logic        i_clear_key,
	input  wire logic        i_switch_enable_jumper,
	input  wire logic        i_output_reset_jumper,
	input  wire logic [6:0]  i_cpu_halted,
	input  wire logic [6:0]  i_tool_resume,
	input  wire logic        i_battery_ok,
	output logic [6:0]       o_halt,
	output logic [6:0]       o_tool_resume,
	output logic             o_outputs_reset,
	output logic             o_led_halt_red,
	output logic             o_led_clear_yellow,
	output logic             o_led_batt_red,
	output logic             o_led_batt_green,
	output logic             o_exc_req,
	output logic [4:0]       o_exc_block,
	output logic             o_full_clear
);

	localparam logic [24:0] DB_LAST  = 25'(DEBOUNCE_CYC - 1);
	localparam logic [24:0] TB_LAST  = 25'(TB_UNIT_CYC - 1);
	localparam logic [24:0] CLR_LAST = 25'(CLEAR_CYC - 1);
	localparam logic [24:0] SEC_LAST = 25'(SECOND_CYC - 1);
	localparam logic [10:0] TC_LAST  = 11'(rhc_pkg::TC_COUNT - 1);

	// ==========================================================
	// Helpers
	function automatic rhc_pkg::rhc_region_type region(input logic [14:0] a, input logic hi0);
		region = rhc_pkg::RG_NONE;
		if (!hi0)
			region = rhc_pkg::RG_NONE;
		else if (a >= rhc_pkg::BASE_REGS)
			region = rhc_pkg::RG_REG;
		else if (a >= rhc_pkg::BASE_TC && a < rhc_pkg::END_TC)
			region = rhc_pkg::RG_TC;
		else if (a >= rhc_pkg::BASE_FLAGS && a < rhc_pkg::END_FLAGS)
			region = rhc_pkg::RG_FLAG;
		else if (a <= rhc_pkg::OFS_CAL_TIME)
			region = rhc_pkg::RG_CTRL;
	endfunction : region

	// Bits of one flag word that lie below the non-volatile boundary.
	function automatic logic [31:0] nv_keep(input logic [7:0] w, input logic [13:0] nv);
		logic [13:0] idx;
		nv_keep = 32'h0000_0000;
		for (int b = 0; b < 32; b++)
		begin
			idx = {1'b0, w, 5'(b)};
			nv_keep[b] = idx < nv;
		end
	endfunction : nv_keep

	function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2:    days_in = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'h1E;
			default: days_in = 5'h1F;
		endcase
	endfunction : days_in

	// ==========================================================
	// Storage; no reset, the backup battery keeps it.
	logic [31:0]                  flags [0:rhc_pkg::FLAG_WORDS-1];
	logic [31:0]                  regs  [0:rhc_pkg::REG_COUNT-1];
	logic [rhc_pkg::TC_WIDTH-1:0] tc    [0:rhc_pkg::TC_COUNT-1];

	logic                 sw_s1_reg, sw_s2_reg, key_s1_reg, key_s2_reg, bat_s1_reg, bat_s2_reg;
	logic                 sw_db_reg, sw_prev_reg, key_db_reg, bat_prev_reg;
	logic [24:0]          sw_cnt_reg, key_cnt_reg;
	logic                 pend_reg, wr_reg, word_reg, hi0_reg;
	logic [14:0]          addr_reg;
	logic [13:0]          flag_decl_reg;
	logic [8:0]           tc_decl_reg;
	logic [9:0]           timebase_reg;
	rhc_pkg::rhc_seq_type seq_reg;
	logic [10:0]          walk_reg;
	logic [24:0]          settle_reg, unit_cnt_reg, sec_cnt_reg;
	logic [9:0]           tb_cnt_reg;
	logic                 scan_reg, batt_pend_reg;
	logic [8:0]           scan_idx_reg;
	logic [5:0]           sec_reg, min_reg, week_reg;
	logic [4:0]           hour_reg, date_reg;
	logic [3:0]           month_reg;
	logic [6:0]           year_reg;
	logic [2:0]           wday_reg;

	logic                   sw_halt, run_edge, cold_go, bus_acc, bus_wr;
	rhc_pkg::rhc_region_type rg;
	logic [31:0]            wdata;
	logic [30:0]            tc_val;

	assign sw_halt = i_switch_enable_jumper & sw_db_reg; // R16
	assign run_edge = i_switch_enable_jumper & sw_prev_reg & ~sw_db_reg; // R22
	assign cold_go  = (seq_reg == rhc_pkg::SEQ_IDLE) & run_edge;
	assign bus_acc  = pend_reg & (seq_reg == rhc_pkg::SEQ_IDLE);
	assign bus_wr   = bus_acc & wr_reg & word_reg;
	assign rg       = region(addr_reg, hi0_reg);
	assign wdata    = i_hwdata;
	assign tc_val   = tc[scan_idx_reg];

	// ==========================================================
	// Input synchronisers and debouncers
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			{sw_s1_reg, sw_s2_reg, key_s1_reg, key_s2_reg} <= 4'h0;
			{bat_s1_reg, bat_s2_reg} <= 2'h3;
		end
		else
		begin
			{sw_s1_reg, sw_s2_reg} <= {i_halt_switch, sw_s1_reg}; // R22
			{key_s1_reg, key_s2_reg} <= {i_clear_key, key_s1_reg};
			{bat_s1_reg, bat_s2_reg} <= {i_battery_ok, bat_s1_reg};
		end
	end

	// A level must stay put for the whole window before it is believed.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			{sw_db_reg, sw_prev_reg, key_db_reg} <= 3'h0;
			sw_cnt_reg  <= 25'h0000000;
			key_cnt_reg <= 25'h0000000;
		end
		else
		begin
			sw_prev_reg <= sw_db_reg;
			sw_cnt_reg  <= (sw_s2_reg == sw_db_reg) ? 25'h0000000 : sw_cnt_reg + 25'h0000001;
			if (sw_s2_reg != sw_db_reg && sw_cnt_reg == DB_LAST)
				sw_db_reg <= sw_s2_reg; // R22
			key_cnt_reg <= (key_s2_reg == key_db_reg) ? 25'h0000000 : key_cnt_reg + 25'h0000001;
			if (key_s2_reg != key_db_reg && key_cnt_reg == DB_LAST)
				key_db_reg <= key_s2_reg;
		end
	end

	// ==========================================================
	// Halt distribution and lamps
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_halt          <= 7'h00;
			o_tool_resume   <= 7'h00;
			o_outputs_reset <= 1'b0;
			o_led_halt_red  <= 1'b0;
		end
		else
		begin
			o_halt[0]       <= sw_halt; // R9
			o_halt[6:1]     <= {6{sw_halt | i_cpu_halted[0]}}; // R17 R18 R19
			o_tool_resume   <= sw_halt ? 7'h00 : i_tool_resume; // R10
			o_outputs_reset <= i_output_reset_jumper & (sw_halt | i_cpu_halted[0]); // R17 R18
			o_led_halt_red  <= sw_halt | (|i_cpu_halted); // R20
		end
	end

	// ==========================================================
	// Cold start and clear sequencer
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			seq_reg            <= rhc_pkg::SEQ_IDLE;
			walk_reg           <= 11'h000;
			settle_reg         <= 25'h0000000;
			o_full_clear       <= 1'b0;
			o_led_clear_yellow <= 1'b0;
		end
		else
		begin
			o_full_clear <= 1'b0;
			case (seq_reg)
				rhc_pkg::SEQ_IDLE:
				begin
					walk_reg   <= 11'h000;
					settle_reg <= 25'h0000000;
					if (run_edge)
					begin
						seq_reg            <= rhc_pkg::SEQ_WALK; // R11
						o_full_clear       <= key_db_reg; // R12 R13 R15
						o_led_clear_yellow <= key_db_reg; // R14
					end
				end
				rhc_pkg::SEQ_WALK:
				begin
					walk_reg <= walk_reg + 11'h001;
					if (walk_reg == TC_LAST)
						seq_reg <= rhc_pkg::SEQ_SETTLE;
				end
				rhc_pkg::SEQ_SETTLE:
				begin
					settle_reg <= settle_reg + 25'h0000001;
					if (!o_led_clear_yellow || settle_reg >= CLR_LAST)
					begin
						seq_reg            <= rhc_pkg::SEQ_IDLE;
						o_led_clear_yellow <= 1'b0; // R14
					end
				end
				default: seq_reg <= rhc_pkg::SEQ_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Exception requests and battery
	// A battery fault met during a cold start waits one request slot.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_exc_req        <= 1'b0;
			o_exc_block      <= 5'h00;
			batt_pend_reg    <= 1'b0;
			bat_prev_reg     <= 1'b1;
			o_led_batt_red   <= 1'b0;
			o_led_batt_green <= 1'b0;
		end
		else
		begin
			bat_prev_reg     <= bat_s2_reg;
			o_led_batt_red   <= ~bat_s2_reg; // R21
			o_led_batt_green <= bat_s2_reg;
			o_exc_req        <= cold_go | (batt_pend_reg & ~cold_go);
			if (cold_go)
				o_exc_block <= rhc_pkg::COLD_START_INIT_BLOCK; // R11
			else if (batt_pend_reg)
				o_exc_block <= rhc_pkg::BATTERY_FAIL_BLOCK; // R21
			if (bat_prev_reg & ~bat_s2_reg)
				batt_pend_reg <= 1'b1;
			else if (!cold_go)
				batt_pend_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Time base and timer scan
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			unit_cnt_reg <= 25'h0000000;
			tb_cnt_reg   <= 10'h000;
			scan_reg     <= 1'b0;
			scan_idx_reg <= 9'h000;
		end
		else
		begin
			unit_cnt_reg <= (unit_cnt_reg == TB_LAST) ? 25'h0000000 : unit_cnt_reg + 25'h0000001;
			if (unit_cnt_reg == TB_LAST)
			begin
				tb_cnt_reg <= (tb_cnt_reg + 10'h001 >= timebase_reg) ? 10'h000
					: tb_cnt_reg + 10'h001;
				if (tb_cnt_reg + 10'h001 >= timebase_reg && tc_decl_reg != 9'h000)
					scan_reg <= 1'b1; // R6
			end
			// The scan yields to a bus write so no timer loses a tick.
			if (scan_reg && seq_reg == rhc_pkg::SEQ_IDLE && !bus_wr)
			begin
				scan_idx_reg <= scan_idx_reg + 9'h001;
				if (scan_idx_reg + 9'h001 >= tc_decl_reg)
				begin
					scan_reg     <= 1'b0;
					scan_idx_reg <= 9'h000;
				end
			end
		end
	end

	// ==========================================================
	// Storage writes: clear walk, then bus, then timer scan
	always_ff @(posedge i_mclk)
	begin
		if (seq_reg == rhc_pkg::SEQ_WALK)
		begin
			if (walk_reg < 11'(rhc_pkg::FLAG_WORDS))
				flags[walk_reg[7:0]] <= o_led_clear_yellow ? 32'h0000_0000
					: flags[walk_reg[7:0]] & nv_keep(walk_reg[7:0], flag_decl_reg); // R1 R12
			if (o_led_clear_yellow || walk_reg < {2'h0, tc_decl_reg})
				tc[walk_reg] <= 31'h0000_0000; // R4 R12
		end
		else if (bus_wr)
		begin
			if (rg == rhc_pkg::RG_FLAG)
				flags[addr_reg[9:2]] <= wdata; // R1
			if (rg == rhc_pkg::RG_TC)
				tc[addr_reg[12:2]] <= wdata[30:0]; // R3 R5
			if (rg == rhc_pkg::RG_REG)
				regs[addr_reg[13:2]] <= wdata; // R2 R8
		end
		else if (scan_reg && seq_reg == rhc_pkg::SEQ_IDLE && tc_val != 31'h0000_0000)
			tc[scan_idx_reg] <= tc_val - 31'h0000_0001; // R6
	end

	// ==========================================================
	// Declarations written by the user program
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			flag_decl_reg <= rhc_pkg::FLAG_DECL_RST;
			tc_decl_reg   <= rhc_pkg::TC_DECL_RST;
			timebase_reg  <= rhc_pkg::TIMEBASE_RST;
		end
		else if (bus_wr && rg == rhc_pkg::RG_CTRL)
		begin
			if (addr_reg == rhc_pkg::OFS_FLAG_DECL)
				flag_decl_reg <= (wdata > 32'(rhc_pkg::FLAG_DECL_MAX)) ? rhc_pkg::FLAG_DECL_MAX
					: wdata[13:0]; // R1
			if (addr_reg == rhc_pkg::OFS_TC_DECL)
				tc_decl_reg <= (wdata > 32'(rhc_pkg::TIMER_MAX)) ? rhc_pkg::TIMER_MAX
					: wdata[8:0]; // R3
			if (addr_reg == rhc_pkg::OFS_TIMEBASE)
				timebase_reg <= (wdata > 32'(rhc_pkg::TIMEBASE_MAX)) ? rhc_pkg::TIMEBASE_MAX
					: (wdata[9:0] == 10'h000) ? rhc_pkg::TIMEBASE_MIN : wdata[9:0]; // R6
		end
	end

	// ==========================================================
	// Calendar clock; a bus write of a whole field group wins over the tick.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sec_cnt_reg <= 25'h0000000;
			{sec_reg, min_reg, hour_reg} <= 17'h00000;
			{date_reg, month_reg, year_reg} <= {5'h01, 4'h1, 7'h00};
			{wday_reg, week_reg} <= {3'h1, 6'h01};
		end
		else
		begin
			sec_cnt_reg <= (sec_cnt_reg == SEC_LAST) ? 25'h0000000 : sec_cnt_reg + 25'h0000001;
			if (bus_wr && rg == rhc_pkg::RG_CTRL && addr_reg == rhc_pkg::OFS_CAL_TIME)
			begin
				sec_reg  <= wdata[rhc_pkg::CT_SEC_LSB +: 6];
				min_reg  <= wdata[rhc_pkg::CT_MIN_LSB +: 6];
				hour_reg <= wdata[rhc_pkg::CT_HOUR_LSB +: 5];
			end
			else if (bus_wr && rg == rhc_pkg::RG_CTRL && addr_reg == rhc_pkg::OFS_CAL_DATE)
			begin
				date_reg  <= wdata[rhc_pkg::CD_DATE_LSB +: 5];
				month_reg <= wdata[rhc_pkg::CD_MONTH_LSB +: 4];
				year_reg  <= wdata[rhc_pkg::CD_YEAR_LSB +: 7];
				wday_reg  <= wdata[rhc_pkg::CD_WDAY_LSB +: 3];
				week_reg  <= wdata[rhc_pkg::CD_WEEK_LSB +: 6];
			end
			else if (sec_cnt_reg == SEC_LAST)
			begin
				sec_reg <= (sec_reg == 6'h3B) ? 6'h00 : sec_reg + 6'h01; // R7
				if (sec_reg == 6'h3B)
					min_reg <= (min_reg == 6'h3B) ? 6'h00 : min_reg + 6'h01;
				if (sec_reg == 6'h3B && min_reg == 6'h3B)
					hour_reg <= (hour_reg == 5'h17) ? 5'h00 : hour_reg + 5'h01;
				if (sec_reg == 6'h3B && min_reg == 6'h3B && hour_reg == 5'h17)
				begin
					wday_reg <= (wday_reg == 3'h7) ? 3'h1 : wday_reg + 3'h1;
					if (wday_reg == 3'h7)
						week_reg <= week_reg + 6'h01;
					date_reg <= (date_reg >= days_in(month_reg, year_reg)) ? 5'h01
						: date_reg + 5'h01;
					if (date_reg >= days_in(month_reg, year_reg))
					begin
						month_reg <= (month_reg == 4'hC) ? 4'h1 : month_reg + 4'h1;
						if (month_reg == 4'hC)
						begin
							year_reg <= (year_reg == 7'h63) ? 7'h00 : year_reg + 7'h01;
							week_reg <= 6'h01;
						end
					end
				end
			end
		end
	end

	// ==========================================================
	// Bus slave: one wait state, longer while the cold start sequencer walks or settles.
	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pend_reg    <= 1'b0;
			{wr_reg, word_reg, hi0_reg} <= 3'h0;
			addr_reg    <= 15'h0000;
			o_hreadyout <= 1'b1;
			o_hrdata    <= 32'h0000_0000;
			o_hresp     <= 1'b0;
		end
		else if (!pend_reg)
		begin
			if (i_hsel && i_htrans[1] && i_hready)
			begin
				pend_reg    <= 1'b1;
				o_hreadyout <= 1'b0;
				wr_reg      <= i_hwrite;
				word_reg    <= i_hsize == 3'h2;
				hi0_reg     <= i_haddr[31:15] == 17'h00000;
				addr_reg    <= {i_haddr[14:2], 2'h0};
			end
		end
		else if (bus_acc)
		begin
			pend_reg    <= 1'b0;
			o_hreadyout <= 1'b1;
			o_hrdata    <= 32'h0000_0000;
			if (!wr_reg)
			begin
				case (rg)
					rhc_pkg::RG_FLAG: o_hrdata <= flags[addr_reg[9:2]];
					rhc_pkg::RG_TC:   o_hrdata <= {1'b0, tc[addr_reg[12:2]]}; // R5
					rhc_pkg::RG_REG:  o_hrdata <= regs[addr_reg[13:2]]; // R8
					rhc_pkg::RG_CTRL:
					begin
						case (addr_reg)
							rhc_pkg::OFS_FLAG_DECL: o_hrdata <= {18'h00000, flag_decl_reg};
							rhc_pkg::OFS_TC_DECL:   o_hrdata <= {23'h000000, tc_decl_reg};
							rhc_pkg::OFS_TIMEBASE:  o_hrdata <= {22'h000000, timebase_reg};
							rhc_pkg::OFS_STATUS:
								o_hrdata <= {21'h000000, o_outputs_reset, bat_s2_reg,
									o_led_clear_yellow, sw_halt, o_halt};
							rhc_pkg::OFS_CAL_DATE:
								o_hrdata <= {7'h00, week_reg, wday_reg, year_reg, month_reg, date_reg};
							rhc_pkg::OFS_CAL_TIME:
								o_hrdata <= {11'h000, hour_reg, 2'h0, min_reg, 2'h0, sec_reg};
							default: o_hrdata <= 32'h0000_0000;
						endcase
					end
					default: o_hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	sw_halt_all_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R9
		sw_halt |=> (o_halt == 7'h7F)) else $error("switch halt did not halt all");
	tool_block_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R10
		sw_halt |=> (o_tool_resume == 7'h00)) else $error("tool resume passed during halt");
	cold_start_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R11
		cold_go |=> o_exc_req && o_exc_block == rhc_pkg::COLD_START_INIT_BLOCK
		##1 seq_reg == rhc_pkg::SEQ_WALK) else $error("cold start not issued");
	full_clear_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R12
		cold_go && key_db_reg |=> o_full_clear && o_led_clear_yellow)
		else $error("full clear missed");
	key_idle_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R13
		seq_reg == rhc_pkg::SEQ_IDLE && !run_edge |=> !o_full_clear && !o_led_clear_yellow)
		else $error("clear key acted outside the run edge");
	yellow_len_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R14
		$fell(o_led_clear_yellow) |-> $past(settle_reg) >= CLR_LAST)
		else $error("yellow lamp dropped early");
	jumper_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R15 R16
		!i_switch_enable_jumper |=> !o_halt[0] && !o_full_clear)
		else $error("switch acted with jumper off");
	out_reset_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R17
		i_output_reset_jumper && i_cpu_halted[0] |=> o_outputs_reset && o_halt[6:1] == 6'h3F)
		else $error("processor 0 halt not spread");
	keep_out_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R18
		!i_output_reset_jumper && i_cpu_halted[0] |=> !o_outputs_reset && o_halt[6:1] == 6'h3F)
		else $error("outputs touched with reset off");
	local_halt_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R19
		!sw_halt && !i_cpu_halted[0] |=> o_halt == 7'h00 && !o_outputs_reset)
		else $error("local halt spread");
	red_lamp_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R20
		(|i_cpu_halted) |=> o_led_halt_red) else $error("red lamp off in halt");
	batt_fail_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R21
		$fell(bat_s2_reg) |=> o_led_batt_red ##[0:2] (o_exc_req
		&& o_exc_block == rhc_pkg::BATTERY_FAIL_BLOCK)) else $error("battery fault not raised");
	timer_cap_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // R3 R6
		tc_decl_reg <= rhc_pkg::TIMER_MAX && timebase_reg >= rhc_pkg::TIMEBASE_MIN
		&& timebase_reg <= rhc_pkg::TIMEBASE_MAX) else $error("declaration out of range");

	cold_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) cold_go && !key_db_reg);
	full_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) cold_go && key_db_reg);
	scan_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) $fell(scan_reg));
	read_c: cover property (@(posedge i_mclk) disable iff (!i_resetn) bus_acc && !wr_reg);

endmodule : rhc_run_halt_clear

/* File: rhc_cpu_model.sv */
`timescale 1ns/100ps
// ==========
// Processor modules: a module halts when forced or when it halts itself.
module rhc_cpu_model (
	input  wire logic       i_mclk,
	input  wire logic [6:0] i_halt,
	input  wire logic [6:0] i_own_halt,
	output logic      [6:0] o_cpu_halted
);
	always_ff @(posedge i_mclk)
	begin
		o_cpu_halted <= i_halt | i_own_halt;
	end
endmodule : rhc_cpu_model

/* File: tb_run_halt_clear.sv */
`timescale 1ns/100ps
module tb_run_halt_clear;
	logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, sw = 0, key = 0, orj = 1, bat = 1;
	logic        hro, hresp, ores, lred, lyel, bred, bgrn, exc, fclr;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [6:0]  tres = 0, own = 0, halted, halt, tout;
	logic [4:0]  blk, last_blk = 0;
	int          fails = 0, n_compared = 0, seen_fc = 0, seen_y = 0;
	int          seen_h = 0, n_cold = 0;
	logic        sej = 1;
	logic [2:0]  hsize = 3'h2;
	always #20 clk = ~clk;
	// Pulses are latched so that a test can judge them after the fact.
	always @(posedge clk)
	begin
		if (exc === 1'b1) last_blk <= blk;
		if (fclr === 1'b1) seen_fc <= 1;
		if (lyel === 1'b1) seen_y <= 1;
		if (halt[0] === 1'b1) seen_h <= 1;
		if (exc === 1'b1 && blk === 5'h10) n_cold <= n_cold + 1;
	end
	rhc_cpu_model i_cpu (.i_mclk(clk), .i_halt(halt), .i_own_halt(own), .o_cpu_halted(halted));
	rhc_run_halt_clear #(.DEBOUNCE_CYC(4), .TB_UNIT_CYC(8), .CLEAR_CYC(20), .SECOND_CYC(16)) i_dut (
		.i_mclk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hro),
		.o_hreadyout(hro), .o_hrdata(hrdata), .o_hresp(hresp), .i_halt_switch(sw),
		.i_clear_key(key), .i_switch_enable_jumper(sej), .i_output_reset_jumper(orj),
		.i_cpu_halted(halted), .i_tool_resume(tres), .i_battery_ok(bat), .o_halt(halt),
		.o_tool_resume(tout), .o_outputs_reset(ores), .o_led_halt_red(lred),
		.o_led_clear_yellow(lyel), .o_led_batt_red(bred), .o_led_batt_green(bgrn),
		.o_exc_req(exc), .o_exc_block(blk), .o_full_clear(fclr));
	// ==========
	// Shared tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// Single word transfer; waits on hready, which stays low through a clear walk.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hro !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hro !== 1'b1);
		r = hrdata;
		chk(32'(hresp), 32'h0);
	endtask : ahb
	task cold(input logic k);
		int c0;
		c0 = n_cold;
		sw <= 1;
		tick(20);
		chk(32'(halt), 32'h7F);
		chk(32'(lred), 32'h1);
		tres <= 7'h7F;
		tick(1);
		tres <= 0;
		tick(1);
		chk(32'(tout), 32'h0);
		key <= k;
		sw <= 0;
		tick(2000);
		key <= 0;
		chk(n_cold, c0 + 1);
		chk(32'(lred), 32'h0);
	endtask : cold
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// ==========
	// Scenarios
	initial
	begin
		tick(20);
		rstn <= 1;
		tick(2);
		ahb(0, 32'hC, 0);
		chk(r, 32'h200);
		ahb(1, 32'h8, 32'hFFF);
		ahb(0, 32'h8, 0);
		chk(r, 32'h3E8);
		ahb(1, 32'h4, 32'h3FF);
		ahb(0, 32'h4, 0);
		chk(r, 32'h1C2);
		ahb(1, 32'h4000, 32'h80000000);
		ahb(1, 32'h2000, 32'hFFFFFFFF);
		ahb(0, 32'h2000, 0);
		chk(r, 32'h7FFFFFFF);
		ahb(1, 32'h27D0, 32'h7);
		ahb(0, 32'h8000, 0);
		chk(r, 32'h0);
		ahb(1, 32'h0, 32'h20);
		ahb(1, 32'h1000, 32'hFFFFFFFF);
		ahb(1, 32'h1004, 32'hFFFFFFFF);
		hsize <= 3'h0;
		ahb(1, 32'h4000, 32'h1);
		hsize <= 3'h2;
		ahb(1, 32'h10, 32'h2F025C);
		ahb(1, 32'h14, 32'h173B3B);
		tick(20);
		ahb(0, 32'h10, 0);
		chk(r, 32'h310261);
		$display("test bus done");
		key <= 1;
		tick(20);
		key <= 0;
		chk(seen_fc, 0);
		sw <= 1;
		tick(2);
		sw <= 0;
		tick(10);
		chk(seen_h, 0);
		sej <= 0;
		sw <= 1;
		key <= 1;
		tick(20);
		chk(32'(halt), 32'h0);
		sw <= 0;
		tick(20);
		sej <= 1;
		key <= 0;
		chk(n_cold, 0);
		chk(seen_fc, 0);
		cold(0);
		chk(seen_y, 0);
		ahb(0, 32'h2000, 0);
		chk(r, 32'h0);
		ahb(0, 32'h27D0, 0);
		chk(r, 32'h7);
		ahb(0, 32'h1000, 0);
		chk(r, 32'hFFFFFFFF);
		ahb(0, 32'h1004, 0);
		chk(r, 32'h0);
		cold(1);
		chk(seen_fc, 1);
		chk(seen_y, 1);
		chk(32'(lyel), 32'h0);
		ahb(0, 32'h27D0, 0);
		chk(r, 32'h0);
		ahb(0, 32'h1000, 0);
		chk(r, 32'h0);
		ahb(0, 32'h4000, 0);
		chk(r, 32'h80000000);
		$display("test cold start done");
		own <= 7'h01;
		tick(5);
		chk(32'({halt, ores}), 32'hFD);
		orj <= 0;
		tick(3);
		chk(32'({halt, ores}), 32'hFC);
		own <= 7'h08;
		tick(5);
		chk(32'({halt, ores}), 32'h0);
		own <= 0;
		$display("test processor halt done");
		ahb(1, 32'h2004, 32'h1);
		ahb(1, 32'h27D0, 32'h3);
		ahb(1, 32'h8, 32'h1);
		tick(1000);
		ahb(0, 32'h2004, 0);
		chk(r, 32'h0);
		ahb(0, 32'h27D0, 0);
		chk(r, 32'h3);
		bat <= 0;
		tick(8);
		chk(32'({bred, bgrn, last_blk}), 32'h42);
		$display("test battery done");
		report_and_stop;
	end
	initial
	begin
		#400000;
		fails++;
		$display("mismatch at %0t: timeout", $time);
		report_and_stop;
	end
endmodule : tb_run_halt_clear
